// [rtl/aio_pkg.sv]
// Constants shared by the analog I/O board data-word block.
// Assumes a 40 MHz system clock and word-indexed Avalon-MM access.
package aio_pkg;
    // Clock and scan timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int SCAN_PERIOD_US = 10;
    localparam int SCAN_CYCLES = SCAN_PERIOD_US * 1000 / CLK_PERIOD_NS;

    // Register indices; byte address is four times the index
    localparam logic [7:0] IDX_IN1 = 8'hE8;
    localparam logic [7:0] IDX_IN2 = 8'hE9;
    localparam logic [7:0] IDX_IN3 = 8'hEA;
    localparam logic [7:0] IDX_IN4 = 8'hEB;
    localparam logic [7:0] IDX_OUT1 = 8'hEC;
    localparam logic [7:0] IDX_OUT2 = 8'hED;
    localparam logic [7:0] IDX_SYS_STATUS = 8'hFE;
    localparam logic [7:0] IDX_ERR_CODE = 8'hF0;
    localparam logic [7:0] IDX_IN_CONFIG = 8'hF1;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hF2;
    localparam logic [7:0] IDX_IRQ_MASK = 8'hF3;

    // Fields
    localparam int NUM_IN = 4;
    localparam int NUM_OUT = 2;
    localparam int ADC_BITS = 12;
    localparam int CFG_EN_LSB = 8;
    localparam int ERR_LSB = 8;
    localparam int SYS_ERR_BIT = 15;
    localparam int IRQ_SCAN_BIT = 0;
    localparam int IRQ_ERR_BIT = 1;
    localparam int IRQ_BITS = 2;

    // Reset values
    localparam logic [15:0] CFG_RESET = 16'h0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [31:0] RDATA_ZERO = 32'h0000_0000;

    // Input signal ranges
    typedef enum logic [1:0] {
        RANGE_BIP10 = 2'b00,
        RANGE_UNI10 = 2'b01,
        RANGE_UNI5 = 2'b10,
        RANGE_UNUSED = 2'b11
    } range_t;

    // Board error codes
    localparam logic [7:0] ERR_NORMAL = 8'h00;
    localparam logic [7:0] ERR_HW_A = 8'h01;
    localparam logic [7:0] ERR_HW_B = 8'h02;
    localparam logic [7:0] ERR_SETUP = 8'h03;
    localparam logic [7:0] ERR_CONV = 8'h04;
endpackage

// [rtl/scan_if.sv]
// Carries the scan-cycle strobe from the scan timer to the board logic.
// Assumes both ends share one clock.
`timescale 1ns/1ps
interface scan_if;
    logic tick;
    modport src (output tick);
    modport dst (input tick);
endinterface

// [rtl/aio_scan_timer.sv]
// Divider that makes the one-cycle scan strobe.
// Assumes an active-low reset copy from the top, asserted at once and released in step with the clock.
`timescale 1ns/1ps
module aio_scan_timer
    import aio_pkg::*;
#(
    parameter int PERIOD = SCAN_CYCLES
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    scan_if.src scan
);
    localparam int CW = $clog2(PERIOD + 1);
    localparam logic [CW-1:0] LAST = CW'(PERIOD - 1);

    logic [CW-1:0] cnt_r;
    logic tick_r;
    wire at_last = (cnt_r == LAST);

    always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt_r <= '0;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= at_last ? '0 : cnt_r + 1'b1;
            tick_r <= at_last;
        end
    end

    assign scan.tick = tick_r;
endmodule

// [rtl/aio_board.sv]
// Analog I/O board data words: four input words, two output settings,
// error code, status flag, configuration and interrupt registers.
// Assumes an Avalon-MM master using word indices and a converter front
// end that presents raw 12-bit offset-binary samples each scan.
// Operation
// - Each scan, every input's result lands in its own 16-bit word.
// - Bipolar 10 V inputs give two's complement F800 up to 07FF.
// - Unipolar inputs give unsigned codes 0000 up to 0FFF.
// - Each scan, both output settings are read and driven out.
// - Any board fault shows at bit 15 of the system status word.
// - Error code byte 15:8: 00 ok, 01/02 hardware, 03 setup, 04 conversion.
// - Config bits 7:0 are four 2-bit input range fields.
// - Config bits 11:8 disable conversion of their input when set.
// - Range and enable settings take effect only once after power-up.
// - Output signal type follows the wired terminal; no range field.
//
// The implementer's own choice: the Avalon-MM register port.
`timescale 1ns/1ps
module aio_board
    import aio_pkg::*;
#(
    parameter int SCAN_PERIOD = SCAN_CYCLES
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_reset_n,
    // Avalon-MM slave, word indexed
    input wire logic [7:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // Converter front end
    input wire logic [NUM_IN*ADC_BITS-1:0] i_adc_sample,
    input wire logic i_adc_error,
    input wire logic i_hw_fault_a,
    input wire logic i_hw_fault_b,
    // Output setting codes to the converters
    output logic [15:0] o_dac_out1,
    output logic [15:0] o_dac_out2,
    // Interrupt
    output logic o_irq
);

////////////////////////////////////////////////////////////////////////////
    // Reset release through two flops
    logic rst_meta_r;
    logic rst_n_r;

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    scan_if scan ();

    aio_scan_timer #(
        .PERIOD(SCAN_PERIOD)
    ) u_timer (
        .i_sys_clk(i_sys_clk),
        .i_rst_n(rst_n_r),
        .scan(scan)
    );

    wire tick = scan.tick;

////////////////////////////////////////////////////////////////////////////
    // Bus decode
    logic waitrequest_r;
    logic [31:0] readdata_r;
    wire req = i_avs_read | i_avs_write;
    wire accept = req & ~waitrequest_r;
    wire wr_acc = accept & i_avs_write;
    wire wr_out1 = wr_acc & (i_avs_address == IDX_OUT1);
    wire wr_out2 = wr_acc & (i_avs_address == IDX_OUT2);
    wire wr_cfg = wr_acc & (i_avs_address == IDX_IN_CONFIG);
    wire wr_irq_sts = wr_acc & (i_avs_address == IDX_IRQ_STATUS);
    wire wr_irq_msk = wr_acc & (i_avs_address == IDX_IRQ_MASK);

    logic [15:0] in_word_r [NUM_IN];
    logic [15:0] out_set_r [NUM_OUT];
    logic [15:0] cfg_r;
    logic [15:0] cfg_act_r;
    logic cfg_done_r;
    logic [7:0] err_code_r;
    logic err_flag_r;
    logic [IRQ_BITS-1:0] irq_sts_r;
    logic [IRQ_BITS-1:0] irq_msk_r;

    logic [15:0] rd_word;
    always_comb begin
        case (i_avs_address)
            IDX_IN1: rd_word = in_word_r[0];
            IDX_IN2: rd_word = in_word_r[1];
            IDX_IN3: rd_word = in_word_r[2];
            IDX_IN4: rd_word = in_word_r[3];
            IDX_OUT1: rd_word = out_set_r[0];
            IDX_OUT2: rd_word = out_set_r[1];
            IDX_SYS_STATUS: rd_word = {err_flag_r, 15'h0000};
            IDX_ERR_CODE: rd_word = {err_code_r, 8'h00};
            IDX_IN_CONFIG: rd_word = cfg_r;
            IDX_IRQ_STATUS: rd_word = {14'h0000, irq_sts_r};
            IDX_IRQ_MASK: rd_word = {14'h0000, irq_msk_r};
            default: rd_word = WORD_ZERO;
        endcase
    end

    // One wait state: request seen, answered on the next edge
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            waitrequest_r <= 1'b1;
            readdata_r <= RDATA_ZERO;
        end else begin
            waitrequest_r <= ~(req & waitrequest_r);
            if (req & waitrequest_r)
                readdata_r <= {16'h0000, rd_word};
        end
    end

////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            out_set_r[0] <= WORD_ZERO;
            out_set_r[1] <= WORD_ZERO;
            cfg_r <= CFG_RESET;
            irq_msk_r <= '0;
        end else begin
            if (wr_out1)
                out_set_r[0] <= i_avs_writedata[15:0];
            if (wr_out2)
                out_set_r[1] <= i_avs_writedata[15:0];
            if (wr_cfg)
                cfg_r <= i_avs_writedata[15:0];
            if (wr_irq_msk)
                irq_msk_r <= i_avs_writedata[IRQ_BITS-1:0];
        end
    end

    // Settings are captured once, at the first scan after reset, so
    // boot code has one scan period to load them; later writes only
    // change the readback until the next reset.
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            cfg_act_r <= CFG_RESET;
            cfg_done_r <= 1'b0;
        end else if (tick & ~cfg_done_r) begin
            cfg_act_r <= cfg_r;
            cfg_done_r <= 1'b1;
        end
    end

////////////////////////////////////////////////////////////////////////////
    // Per-input conversion
    logic [15:0] conv_word [NUM_IN];
    logic [NUM_IN-1:0] bad_range;
    // The capturing scan already converts with the captured settings
    wire [15:0] cfg_use = cfg_done_r ? cfg_act_r : cfg_r;

    for (genvar ch = 0; ch < NUM_IN; ch++) begin : g_in
        wire [ADC_BITS-1:0] raw = i_adc_sample[ch*ADC_BITS +: ADC_BITS];
        wire [1:0] rng = cfg_use[2*ch +: 2];
        wire en = ~cfg_use[CFG_EN_LSB + ch];
        // Offset binary minus midscale, sign extended
        wire [15:0] bip = {{5{~raw[11]}}, raw[10:0]};
        wire [15:0] uni = {4'h0, raw};
        assign bad_range[ch] = en & (rng == RANGE_UNUSED);
        assign conv_word[ch] = !en ? WORD_ZERO :
            (rng == RANGE_BIP10) ? bip :
            (rng == RANGE_UNUSED) ? WORD_ZERO : uni;

        always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
            if (!rst_n_r)
                in_word_r[ch] <= WORD_ZERO;
            else if (tick)
                in_word_r[ch] <= conv_word[ch];
        end
    end

////////////////////////////////////////////////////////////////////////////
    // Errors, outputs and interrupts
    wire [7:0] err_nxt = i_hw_fault_a ? ERR_HW_A :
        i_hw_fault_b ? ERR_HW_B :
        (|bad_range) ? ERR_SETUP :
        i_adc_error ? ERR_CONV : ERR_NORMAL;
    wire err_rise = (err_nxt != ERR_NORMAL) & ~err_flag_r;
    logic [IRQ_BITS-1:0] irq_set;
    assign irq_set = {tick & err_rise, tick};
    wire [IRQ_BITS-1:0] irq_clr = wr_irq_sts ?
        i_avs_writedata[IRQ_BITS-1:0] : '0;

    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            err_code_r <= ERR_NORMAL;
            err_flag_r <= 1'b0;
            o_dac_out1 <= WORD_ZERO;
            o_dac_out2 <= WORD_ZERO;
        end else if (tick) begin
            err_code_r <= err_nxt;
            err_flag_r <= (err_nxt != ERR_NORMAL);
            // Codes pass unchanged; the wired terminal picks the type
            o_dac_out1 <= out_set_r[0];
            o_dac_out2 <= out_set_r[1];
        end
    end

    // A set in the same cycle as its clear wins
    always_ff @(posedge i_sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
            irq_sts_r <= '0;
            o_irq <= 1'b0;
        end else begin
            irq_sts_r <= (irq_sts_r & ~irq_clr) | irq_set;
            o_irq <= |(((irq_sts_r & ~irq_clr) | irq_set) & irq_msk_r);
        end
    end

    assign o_avs_readdata = readdata_r;
    assign o_avs_waitrequest = waitrequest_r;

////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!rst_n_r);

    sequence s_scan_bip0;
        tick && cfg_done_r && !cfg_act_r[CFG_EN_LSB]
            && cfg_act_r[1:0] == RANGE_BIP10;
    endsequence

    sequence s_bus_read;
        i_avs_read && waitrequest_r;
    endsequence

    sequence s_bus_req;
        (i_avs_read || i_avs_write) && waitrequest_r;
    endsequence

    AST_IN1_WRITTEN: assert property (tick |=>
        in_word_r[0] == $past(conv_word[0]))
        else $error("input word 1 not refreshed on scan");

    AST_BIP_RANGE: assert property (s_scan_bip0 |=>
        in_word_r[0] == {{5{~$past(i_adc_sample[11])}},
        $past(i_adc_sample[10:0])})
        else $error("bipolar code wrong");

    AST_UNI_RANGE: assert property ((tick && cfg_done_r
        && !cfg_act_r[CFG_EN_LSB + 1]
        && cfg_act_r[3:2] == RANGE_UNI10) |=>
        in_word_r[1][15:12] == 4'h0)
        else $error("unipolar code above 0FFF");

    AST_DAC_FOLLOWS: assert property (tick |=>
        o_dac_out2 == $past(out_set_r[1]))
        else $error("output 2 not refreshed on scan");

    AST_DAC_HOLDS: assert property (!tick |=> $stable(o_dac_out1))
        else $error("output 1 moved between scans");

    AST_SYS_FLAG: assert property (s_bus_read ##0
        (i_avs_address == IDX_SYS_STATUS) ##1 !waitrequest_r
        |-> readdata_r[SYS_ERR_BIT] == $past(err_flag_r))
        else $error("status flag readback wrong");

    AST_SETUP_CODE: assert property ((tick && !i_hw_fault_a
        && !i_hw_fault_b && |bad_range) |=> err_code_r == ERR_SETUP)
        else $error("setup fault not reported");

    AST_DISABLED_ZERO: assert property ((tick
        && cfg_act_r[CFG_EN_LSB + 2]) |=> in_word_r[2] == WORD_ZERO)
        else $error("disabled input converted");

    AST_CFG_FROZEN: assert property ((cfg_done_r && !tick) [*2]
        |-> $stable(cfg_act_r))
        else $error("configuration changed after power-up");

    AST_FLAG_CODE: assert property ($rose(err_flag_r)
        |-> err_code_r != ERR_NORMAL && $past(tick))
        else $error("error flag without error code");

    AST_IRQ_LEVEL: assert property (|(irq_sts_r & irq_msk_r)
        && !wr_irq_sts |=> o_irq)
        else $error("interrupt not raised");

    AST_WAIT_ONE: assert property (s_bus_req |=> !waitrequest_r
        ##1 waitrequest_r)
        else $error("bus answer not after exactly one wait state");

    AST_WRITE_LANDS: assert property (wr_out1 |=>
        out_set_r[0] == $past(i_avs_writedata[15:0]))
        else $error("output 1 setting write lost");

    AST_DAC1_FOLLOWS: assert property (tick |=>
        o_dac_out1 == $past(out_set_r[0]))
        else $error("output 1 not refreshed on scan");

    AST_UNI5_RANGE: assert property ((tick && cfg_done_r
        && !cfg_act_r[CFG_EN_LSB + 2]
        && cfg_act_r[5:4] == RANGE_UNI5) |=>
        in_word_r[2] == {4'h0, $past(i_adc_sample[35:24])})
        else $error("unipolar code not zero extended");

    AST_UNUSED_ZERO: assert property ((tick && cfg_done_r
        && cfg_act_r[1:0] == RANGE_UNUSED) |=> in_word_r[0] == WORD_ZERO)
        else $error("unused range gave a nonzero word");

    AST_HW_A_CODE: assert property (tick && i_hw_fault_a |=>
        err_code_r == ERR_HW_A)
        else $error("hardware fault a not reported");

    AST_HW_B_CODE: assert property ((tick && !i_hw_fault_a
        && i_hw_fault_b) |=> err_code_r == ERR_HW_B)
        else $error("hardware fault b not reported");

    AST_CONV_CODE: assert property ((tick && !i_hw_fault_a
        && !i_hw_fault_b && !(|bad_range) && i_adc_error)
        |=> err_code_r == ERR_CONV)
        else $error("conversion fault not reported");

    AST_NORMAL_CODE: assert property ((tick && !i_hw_fault_a
        && !i_hw_fault_b && !(|bad_range) && !i_adc_error)
        |=> err_code_r == ERR_NORMAL)
        else $error("error code not cleared");

    AST_FLAG_MATCH: assert property (err_flag_r ==
        (err_code_r != ERR_NORMAL))
        else $error("error flag and error code disagree");

    AST_SCAN_IRQ: assert property (tick |=> irq_sts_r[IRQ_SCAN_BIT])
        else $error("scan done bit not set");

    AST_IRQ_CLEARED: assert property ((wr_irq_sts && !tick
        && i_avs_writedata[IRQ_SCAN_BIT]) |=> !irq_sts_r[IRQ_SCAN_BIT])
        else $error("scan done bit not cleared");

    AST_IRQ_MASKED: assert property (irq_msk_r == '0 |=> !o_irq)
        else $error("interrupt raised while all sources masked");

    AST_IN_RO: assert property ((wr_acc && i_avs_address == IDX_IN1
        && !tick) |=> $stable(in_word_r[0]))
        else $error("software write changed an input word");
endmodule

// [tb/aio_adc_model.sv]
// Converter front end model: raw samples and fault lines to the board.
// Assumes the bench sets levels and faults by non-blocking assignment.
`timescale 1ns/1ps
module aio_adc_model (
    // Clock
    input wire logic i_sys_clk,
    // Levels and faults chosen by the bench
    input wire logic [47:0] i_level,
    input wire logic [2:0] i_fault,
    // Front end toward the board
    output logic [47:0] o_adc_sample,
    output logic o_adc_error,
    output logic o_hw_fault_a,
    output logic o_hw_fault_b
);
    initial begin
        o_adc_sample = 48'h0000_0000_0000;
        {o_adc_error, o_hw_fault_b, o_hw_fault_a} = 3'b000;
    end
    // Settles one clock after a level change, so the board never sees
    // a level that moved in the cycle it samples
    always @(posedge i_sys_clk) begin
        o_adc_sample <= i_level;
        {o_adc_error, o_hw_fault_b, o_hw_fault_a} <= i_fault;
    end
endmodule

// [tb/aio_board_tb.sv]
// Self-checking bench for the analog I/O board data words.
// Assumes a short scan of 8 cycles and the converter model beside it.
`timescale 1ns/1ps
module aio_board_tb
    import aio_pkg::*;
;
    localparam logic [15:0] CFG_MAIN = 16'h0864;
    typedef struct {
        logic [47:0] raw;
        logic [15:0] o1;
        logic [15:0] o2;
        logic [63:0] e;
    } row_t;
    row_t rows [4] = '{
        '{48'h555F_FF00_0000, 16'hF800, 16'h07FF, 64'h0000_0FFF_0000_F800},
        '{48'hFFF0_00FF_FFFF, 16'h07FF, 16'h0000, 64'h0000_0000_0FFF_07FF},
        '{48'h0018_017F_F800, 16'h0000, 16'h0400, 64'h0000_0801_07FF_0000},
        '{48'h000A_BC12_37FF, 16'hFC00, 16'h0001, 64'h0000_0ABC_0123_FFFF}};
    logic [2:0] flt [6] = '{3'b001, 3'b011, 3'b010, 3'b100, 3'b110, 3'b000};
    logic [7:0] code [6] = '{ERR_HW_A, ERR_HW_A, ERR_HW_B, ERR_CONV,
        ERR_HW_B, ERR_NORMAL};
    logic sys_clk = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] addr = 8'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0000_0000;
    logic [31:0] rdata;
    logic waitreq;
    logic [47:0] raw = 48'h0000_0000_0000;
    logic [2:0] fault = 3'b000;
    logic [47:0] sample;
    logic adc_err, hw_a, hw_b, irq;
    logic [15:0] dac1, dac2, got;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;

    always #12.5 sys_clk = ~sys_clk;

    aio_board #(.SCAN_PERIOD(8)) i_aio_board (.i_sys_clk(sys_clk),
        .i_reset_n(reset_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_adc_sample(sample),
        .i_adc_error(adc_err), .i_hw_fault_a(hw_a), .i_hw_fault_b(hw_b),
        .o_dac_out1(dac1), .o_dac_out2(dac2), .o_irq(irq));
    aio_adc_model i_aio_adc_model (.i_sys_clk(sys_clk), .i_level(raw),
        .i_fault(fault), .o_adc_sample(sample), .o_adc_error(adc_err),
        .o_hw_fault_a(hw_a), .o_hw_fault_b(hw_b));

    ////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check_word(string name, logic [15:0] exp, logic [15:0] s);
        comparisons++;
        if (s !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", name, exp, s);
        end
    endtask

    // Holds the request until waitrequest is seen low at a rising edge
    task automatic bus(logic w, logic [7:0] a, logic [15:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= {16'h0000, d};
        rd <= !w;
        wr <= w;
        // Only the bench timeout ends a wait that is never answered
        do
            @(posedge sys_clk);
        while (waitreq !== 1'b0);
        got = rdata[15:0];
        rd <= 1'b0;
        wr <= 1'b0;
    endtask

    task automatic rchk(string name, logic [7:0] a, logic [15:0] exp);
        bus(1'b0, a, 16'h0000);
        check_word(name, exp, got);
    endtask

    // Clears the scan-done bit and polls until a fresh scan sets it
    task automatic next_scan();
        bus(1'b1, IDX_IRQ_STATUS, 16'h0001);
        do
            bus(1'b0, IDX_IRQ_STATUS, 16'h0000);
        while (got[IRQ_SCAN_BIT] !== 1'b1);
    endtask

    task automatic do_reset(logic [15:0] cfg);
        reset_n <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check_word("waitrequest", 16'h0001, {15'h0, waitreq});
        check_word("dac in reset", 16'h0000, dac1 | dac2);
        check_word("irq in reset", 16'h0000, {15'h0, irq});
        reset_n <= 1'b1;
        repeat (3) @(posedge sys_clk);
        // Config must land before the first scan captures it
        bus(1'b1, IDX_IN_CONFIG, cfg);
        next_scan();
    endtask

    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            conclude();
        end
    end

    ////////////////////////////////////////////////////////////////////
    initial begin
        do_reset(CFG_MAIN);
        rchk("config", IDX_IN_CONFIG, CFG_MAIN);
        for (int r = 0; r < 4; r++) begin
            raw <= rows[r].raw;
            bus(1'b1, IDX_OUT1, rows[r].o1);
            bus(1'b1, IDX_OUT2, rows[r].o2);
            next_scan();
            for (int k = 0; k < 4; k++)
                rchk("input word", IDX_IN1 + 8'(k), rows[r].e[16*k+:16]);
            check_word("out1", rows[r].o1, dac1);
            check_word("out2", rows[r].o2, dac2);
            rchk("out2 readback", IDX_OUT2, rows[r].o2);
        end
        $display("test rows done");
        bus(1'b1, IDX_IN_CONFIG, 16'h0000);
        bus(1'b1, IDX_IN1, 16'h1234);
        bus(1'b1, 8'h10, 16'h5555);
        next_scan();
        rchk("config readback", IDX_IN_CONFIG, 16'h0000);
        rchk("input 4 still off", IDX_IN4, 16'h0000);
        rchk("input 2 still unipolar", IDX_IN2, 16'h0123);
        rchk("read-only word", IDX_IN1, 16'hFFFF);
        rchk("unmapped", 8'h10, 16'h0000);
        check_word("readdata high half", 16'h0000, rdata[31:16]);
        $display("test late config done");
        bus(1'b1, IDX_IRQ_MASK, 16'h0002);
        for (int f = 0; f < 6; f++) begin
            fault <= flt[f];
            next_scan();
            rchk("error code", IDX_ERR_CODE, {code[f], 8'h00});
            bus(1'b0, IDX_SYS_STATUS, 16'h0000);
            check_word("error flag", {15'h0, code[f] != ERR_NORMAL},
                {15'h0, got[SYS_ERR_BIT]});
        end
        check_word("irq raised", 16'h0001, {15'h0, irq});
        bus(1'b1, IDX_IRQ_MASK, 16'h0000);
        repeat (2) @(posedge sys_clk);
        check_word("irq masked", 16'h0000, {15'h0, irq});
        bus(1'b1, IDX_IRQ_MASK, 16'h0002);
        repeat (2) @(posedge sys_clk);
        check_word("irq unmasked", 16'h0001, {15'h0, irq});
        bus(1'b1, IDX_IRQ_STATUS, 16'h0002);
        repeat (2) @(posedge sys_clk);
        check_word("irq cleared", 16'h0000, {15'h0, irq});
        $display("test errors done");
        // Second power-up with an unused range on input 1
        do_reset(16'h0003);
        rchk("setup error", IDX_ERR_CODE, {ERR_SETUP, 8'h00});
        rchk("unused range word", IDX_IN1, 16'h0000);
        bus(1'b0, IDX_SYS_STATUS, 16'h0000);
        check_word("setup flag", 16'h0001, {15'h0, got[SYS_ERR_BIT]});
        $display("test second reset done");
        conclude();
    end
endmodule
